// ==== ee_bus_if.sv ====
// Two-wire bus between master and memory slave, with pull-up resolution
`timescale 1ns/1ps
`default_nettype none
interface ee_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Pull-ups: a line is low only while someone drives a zero
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
  modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface // ee_bus_if
`default_nettype wire

// ==== ee_defines.svh ====
// Shared constants for the two-wire serial memory slave and its bus master
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH
`define EE_DEV_CODE 4'ha
`define EE_ADDR_BITS 15
`define EE_PAGE_BITS 6
`define EE_BYTE_BITS 4'd8
`define EE_TX_LAST 4'd7
`define EE_CLK_NS 50
`define EE_TI_NS 100
`define EE_TWR_NS 5000000
`define EE_SCL_NS 10000
`define EE_FIFO_DEPTH 8
`endif

// ==== ee_link_monitor.sv ====
// Concurrent checks on the two-wire link between master and memory slave
`timescale 1ns/1ps
`default_nettype none
module ee_link_monitor
#(
  parameter int TWR_CYC = 20
)
(
  input wire logic clock, // system clock
  input wire logic resetn, // async reset
  input wire logic m_scl_o, // master scl value
  input wire logic m_scl_oe, // master scl pull
  input wire logic m_sda_o, // master sda value
  input wire logic m_sda_oe, // master sda pull
  input wire logic s_sda_o, // slave sda value
  input wire logic s_sda_oe, // slave sda pull
  input wire logic scl, // resolved clock wire
  input wire logic sda, // resolved data wire
  input wire logic busy // slave write cycle
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [31:0] busy_cnt_r;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= busy ? busy_cnt_r + 32'h1 : 32'h0;
  end
  slave_open_drain_a: assert property (s_sda_o == 1'b0) else $error("slave drives sda high");
  master_open_drain_a: assert property (m_sda_o == 1'b0 && m_scl_o == 1'b0) else $error("master drives high");
  slave_edge_low_a: assert property ($changed(s_sda_oe) |-> !scl && !$past(scl, 2)) else $error("sda moved near scl high");
  high_stable_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe)) else $error("slave sda moved in scl high");
  busy_quiet_a: assert property (busy |-> !s_sda_oe) else $error("slave answered while busy");
  busy_length_a: assert property ($fell(busy) |-> busy_cnt_r == TWR_CYC) else $error("write cycle length wrong");
  busy_after_stop_a: assert property ($rose(busy) |-> scl && sda) else $error("write cycle without stop");
  ack_hold_a: assert property (s_sda_oe && $rose(scl) |-> ##1 (s_sda_oe && scl) [*3]) else $error("low bit not held");
  scl_high_min_a: assert property ($rose(scl) |-> scl [*8]) else $error("scl high too short");
  cover property ($rose(busy));
  cover property (s_sda_oe && $rose(scl));
  cover property ($fell(sda) && scl);
endmodule // ee_link_monitor
`default_nettype wire

// ==== ee_master.sv ====
// Bus master end with write-data FIFO: issues writes and reads to the slave
`include "ee_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ee_fifo
#(
  parameter int W = 8,
  parameter int DEPTH = `EE_FIFO_DEPTH
)
(
  input wire logic clock, // system clock
  input wire logic resetn, // async reset
  input wire logic in_valid, // write strobe
  output logic in_ready, // space available
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // read strobe
  output logic [W-1:0] out_data // head word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic nfull;
  } ee_fifo_t;
  ee_fifo_t f_r;
  ee_fifo_t f_nxt;
  logic push;
  logic pop;
  assign push = in_valid && f_r.nfull;
  assign pop = out_ready && f_r.cnt != '0;
  always_comb
  begin
    f_nxt = f_r;
    if (push)
    begin
      f_nxt.mem[f_r.wp] = in_data;
      f_nxt.wp = (f_r.wp == AW'(DEPTH - 1)) ? '0 : f_r.wp + AW'(1);
    end
    if (pop)
      f_nxt.rp = (f_r.rp == AW'(DEPTH - 1)) ? '0 : f_r.rp + AW'(1);
    f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    f_nxt.nfull = f_nxt.cnt != (AW+1)'(DEPTH);
  end
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      f_r <= '0;
      f_r.nfull <= 1'b1;
    end
    else
      f_r <= f_nxt;
  end
  assign in_ready = f_r.nfull;
  assign out_valid = f_r.cnt != '0;
  assign out_data = f_r.mem[f_r.rp];
endmodule // ee_fifo

module ee_master
  import ee_pkg::*;
#(
  parameter int QTR_CYC = `EE_SCL_NS / (4 * `EE_CLK_NS),
  parameter int DEPTH = `EE_FIFO_DEPTH
)
(
  input wire logic clock, // system clock
  input wire logic resetn, // async reset
  ee_bus_if.master bus, // two-wire bus
  input wire logic cmd_valid, // command request
  output logic cmd_ready, // idle, command accepted when both high and scl and sda are high
  input wire logic cmd_read, // 1 read, 0 write
  input wire logic cmd_seladdr, // read from cmd_addr, else from counter
  input wire logic [2:0] cmd_sel, // strap select of target
  input wire logic [15:0] cmd_addr, // memory address
  input wire logic [7:0] cmd_len, // byte count
  input wire logic wd_valid, // write data strobe
  output logic wd_ready, // FIFO space
  input wire logic [7:0] wd_data, // write data
  output logic rd_valid, // read byte pulse
  output logic [7:0] rd_data, // read byte
  output logic done, // command end pulse
  output logic nack // last command refused
);
  localparam int QW = $clog2(QTR_CYC + 1);
  typedef struct packed {
    ee_mst_t st;
    ee_seg_t seg;
    logic [1:0] q;
    logic [QW-1:0] tick;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [8:0] rx;
    logic rd;
    logic seladdr;
    logic rstart;
    logic [2:0] sel;
    logic [15:0] addr;
    logic [7:0] len;
    logic scl_oe;
    logic sda_oe;
    logic cmd_ready;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
    logic nack;
  } ee_mstr_t;
  ee_mstr_t m_r;
  ee_mstr_t m_nxt;
  logic fifo_ov;
  logic [7:0] fifo_d;
  logic pop;

  ee_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(wd_valid),
    .in_ready(wd_ready),
    .in_data(wd_data),
    .out_valid(fifo_ov),
    .out_ready(pop),
    .out_data(fifo_d)
  );

  function automatic ee_mstr_t load(ee_mstr_t s, logic [8:0] v);
    s.sh = v;
    s.sda_oe = !v[8];
    s.bitn = 4'd0;
    s.q = 2'd0;
    s.st = MS_BIT;
    return s;
  endfunction

  always_comb
  begin
    logic step;
    logic devrd;
    step = m_r.tick == QW'(QTR_CYC - 1);
    devrd = m_r.rd && (!m_r.seladdr || m_r.rstart);
    pop = 1'b0;
    m_nxt = m_r;
    m_nxt.rd_valid = 1'b0;
    m_nxt.done = 1'b0;
    if (m_r.st != MS_IDLE)
    begin
      m_nxt.tick = step ? '0 : m_r.tick + QW'(1);
      if (step)
        m_nxt.q = m_r.q + 2'd1;
    end
    case (m_r.st)
      MS_IDLE:
      begin
        if (cmd_valid && m_r.cmd_ready && bus.scl && bus.sda)
        begin
          m_nxt.cmd_ready = 1'b0;
          m_nxt.st = MS_START;
          m_nxt.rd = cmd_read;
          m_nxt.seladdr = cmd_seladdr;
          m_nxt.sel = cmd_sel;
          m_nxt.addr = cmd_addr;
          m_nxt.len = cmd_len;
          m_nxt.rstart = 1'b0;
          m_nxt.nack = 1'b0;
          m_nxt.seg = SG_DEV;
        end
      end
      MS_START:
      begin
        if (step)
        begin
          case (m_r.q)
            2'd0: m_nxt.sda_oe = 1'b0;
            2'd1: m_nxt.scl_oe = 1'b0;
            2'd2: m_nxt.sda_oe = 1'b1;
            default:
            begin
              m_nxt.scl_oe = 1'b1;
              m_nxt = load(m_nxt, {`EE_DEV_CODE, m_r.sel, devrd, 1'b1});
            end
          endcase
        end
      end
      MS_BIT:
      begin
        if (step)
        begin
          case (m_r.q)
            2'd0: m_nxt.scl_oe = 1'b0;
            2'd1: m_nxt.rx = {m_r.rx[7:0], bus.sda};
            2'd2: m_nxt.scl_oe = 1'b1;
            default:
            begin
              if (m_r.bitn != `EE_BYTE_BITS)
              begin
                m_nxt.bitn = m_r.bitn + 4'd1;
                m_nxt.sh = {m_r.sh[7:0], 1'b1};
                m_nxt.sda_oe = !m_r.sh[7];
              end
              else
              begin
                m_nxt.st = MS_STOP;
                m_nxt.sda_oe = 1'b1;
                case (m_r.seg)
                  SG_DEV:
                  begin
                    m_nxt.nack = m_r.rx[0];
                    if (!m_r.rx[0] && devrd)
                    begin
                      m_nxt.seg = SG_RD;
                      m_nxt = load(m_nxt, {8'hff, m_r.len <= 8'd1});
                    end
                    else if (!m_r.rx[0])
                    begin
                      m_nxt.seg = SG_AHI;
                      m_nxt = load(m_nxt, {m_r.addr[15:8], 1'b1});
                    end
                  end
                  SG_AHI:
                  begin
                    m_nxt.seg = SG_ALO;
                    m_nxt = load(m_nxt, {m_r.addr[7:0], 1'b1});
                  end
                  SG_ALO, SG_WD:
                  begin
                    m_nxt.nack = m_r.rx[0];
                    if (m_r.seg == SG_WD)
                      m_nxt.len = m_r.len - 8'd1;
                    if (m_r.rx[0] || m_nxt.len == 8'd0)
                      m_nxt.st = MS_STOP;
                    else if (m_r.rd)
                    begin
                      m_nxt.rstart = 1'b1;
                      m_nxt.seg = SG_DEV;
                      m_nxt.st = MS_START;
                    end
                    else if (!fifo_ov)
                    begin
                      m_nxt.st = MS_BIT;
                      m_nxt.q = m_r.q;
                      m_nxt.tick = m_r.tick;
                      m_nxt.sda_oe = m_r.sda_oe;
                      m_nxt.len = m_r.len;
                    end
                    else
                    begin
                      pop = 1'b1;
                      m_nxt.seg = SG_WD;
                      m_nxt = load(m_nxt, {fifo_d, 1'b1});
                    end
                  end
                  default:
                  begin
                    m_nxt.rd_valid = 1'b1;
                    m_nxt.rd_data = m_r.rx[8:1];
                    m_nxt.len = m_r.len - 8'd1;
                    if (m_r.len > 8'd1)
                      m_nxt = load(m_nxt, {8'hff, m_r.len <= 8'd2});
                  end
                endcase
              end
            end
          endcase
        end
      end
      default:
      begin
        if (step)
        begin
          case (m_r.q)
            2'd0: m_nxt.sda_oe = 1'b1;
            2'd1: m_nxt.scl_oe = 1'b0;
            2'd2: m_nxt.sda_oe = 1'b0;
            default:
            begin
              m_nxt.st = MS_IDLE;
              m_nxt.done = 1'b1;
              m_nxt.cmd_ready = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      m_r <= '0;
      m_r.cmd_ready <= 1'b1;
    end
    else
      m_r <= m_nxt;
  end

  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = m_r.scl_oe;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = m_r.sda_oe;
  assign cmd_ready = m_r.cmd_ready;
  assign rd_valid = m_r.rd_valid;
  assign rd_data = m_r.rd_data;
  assign done = m_r.done;
  assign nack = m_r.nack;
endmodule // ee_master
`default_nettype wire

// ==== ee_pkg.sv ====
// Types shared by both ends of the serial memory link
package ee_pkg;
  typedef enum logic [2:0] {SS_IDLE, SS_RX, SS_ACK, SS_TX, SS_MACK} ee_sst_t;
  typedef enum logic [1:0] {PH_DEV, PH_AHI, PH_ALO, PH_DATA} ee_phase_t;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} ee_mst_t;
  typedef enum logic [2:0] {SG_DEV, SG_AHI, SG_ALO, SG_WD, SG_RD} ee_seg_t;
endpackage

// ==== ee_slave.sv ====
// Serial memory slave end: bus decoding, page buffer, write cycle and array
`include "ee_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ee_slave
  import ee_pkg::*;
#(
  parameter int ADDR_W = `EE_ADDR_BITS,
  parameter int TWR_CYC = `EE_TWR_NS / `EE_CLK_NS
)
(
  input wire logic clock, // system clock
  input wire logic resetn, // power-up reset
  ee_bus_if.slave bus, // two-wire bus
  input wire logic strap_sel_bit0, // address strap 0
  input wire logic strap_sel_bit1, // address strap 1
  input wire logic strap_sel_bit2, // address strap 2
  input wire logic wp, // write protect, high blocks writes
  output logic busy // internal write cycle running
);
  localparam int PB = `EE_PAGE_BITS;
  localparam int PAGE = 1 << PB;
  localparam int MEM = 1 << ADDR_W;
  localparam int FILT_RAW = `EE_TI_NS / `EE_CLK_NS;
  localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;
  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int TW = $clog2(TWR_CYC + 1);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] filt;
    logic [1:0][FW-1:0] fcnt;
    logic [1:0] prev;
    ee_sst_t st;
    ee_phase_t ph;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic [7:0] ahi;
    logic [ADDR_W-1:0] cnt;
    logic [PAGE-1:0][7:0] pbuf;
    logic [PAGE-1:0] pmask;
    logic busy;
    logic [TW-1:0] wcnt;
    logic sda_oe;
    logic [MEM-1:0][7:0] mem;
  } ee_slv_t;

  ee_slv_t r_r;
  ee_slv_t r_nxt;
  logic scl_f;
  logic sda_f;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [2:0] straps;

  // Bit 1 carries SCL, bit 0 SDA, after synchroniser and glitch filter
  assign scl_f = r_r.filt[1];
  assign sda_f = r_r.filt[0];
  assign rise = scl_f && !r_r.prev[1];
  assign fall = !scl_f && r_r.prev[1];
  assign start = scl_f && r_r.prev[1] && r_r.prev[0] && !sda_f;
  assign stop = scl_f && r_r.prev[1] && !r_r.prev[0] && sda_f;
  // Straps are compared as driven; nothing here ties unconnected straps low
  assign straps = {strap_sel_bit2, strap_sel_bit1, strap_sel_bit0};

  function automatic ee_slv_t load_tx(ee_slv_t s);
    s.sh = s.mem[s.cnt];
    s.sda_oe = !s.mem[s.cnt][7];
    s.cnt = s.cnt + ADDR_W'(1);
    s.bits = 4'd0;
    s.st = SS_TX;
    return s;
  endfunction

  always_comb
  begin
    logic ack;
    ack = 1'b0;
    r_nxt = r_r;
    r_nxt.s1 = {bus.scl, bus.sda};
    r_nxt.s2 = r_r.s1;
    // Needs FILT_CYC steady samples, so spikes shorter than that never reach the decoder
    for (int i = 0; i < 2; i++)
    begin
      if (r_r.s2[i] == r_r.filt[i])
        r_nxt.fcnt[i] = '0;
      else if (r_r.fcnt[i] == FW'(FILT_CYC - 1))
      begin
        r_nxt.filt[i] = r_r.s2[i];
        r_nxt.fcnt[i] = '0;
      end
      else
        r_nxt.fcnt[i] = r_r.fcnt[i] + FW'(1);
    end
    r_nxt.prev = r_r.filt;
    if (r_r.busy)
    begin
      if (r_r.wcnt == '0)
      begin
        for (int i = 0; i < PAGE; i++)
        begin
          if (r_r.pmask[i])
            r_nxt.mem[{r_r.cnt[ADDR_W-1:PB], PB'(i)}] = r_r.pbuf[i];
        end
        r_nxt.pmask = '0;
        r_nxt.busy = 1'b0;
      end
      else
        r_nxt.wcnt = r_r.wcnt - TW'(1);
    end
    if (start)
    begin
      r_nxt.st = SS_RX;
      r_nxt.ph = PH_DEV;
      r_nxt.bits = 4'd0;
      r_nxt.sda_oe = 1'b0;
      if (!r_r.busy)
        r_nxt.pmask = '0;
    end
    else if (stop)
    begin
      r_nxt.st = SS_IDLE;
      r_nxt.sda_oe = 1'b0;
      if (!r_r.busy && r_r.pmask != '0)
      begin
        if (wp)
          r_nxt.pmask = '0;
        else
        begin
          r_nxt.busy = 1'b1;
          r_nxt.wcnt = TW'(TWR_CYC - 1);
        end
      end
    end
    else
    begin
      case (r_r.st)
        SS_RX:
        begin
          if (rise)
          begin
            r_nxt.sh = {r_r.sh[6:0], sda_f};
            r_nxt.bits = r_r.bits + 4'd1;
          end
          else if (fall && r_r.bits == `EE_BYTE_BITS)
          begin
            ack = 1'b1;
            case (r_r.ph)
              PH_DEV:
              begin
                ack = r_r.sh[7:4] == `EE_DEV_CODE && r_r.sh[3:1] == straps && !r_r.busy;
                r_nxt.rw = r_r.sh[0];
                r_nxt.ph = PH_AHI;
              end
              PH_AHI:
              begin
                r_nxt.ahi = r_r.sh;
                r_nxt.ph = PH_ALO;
              end
              PH_ALO:
              begin
                r_nxt.cnt = ADDR_W'({r_r.ahi, r_r.sh});
                r_nxt.ph = PH_DATA;
              end
              default:
              begin
                r_nxt.pbuf[r_r.cnt[PB-1:0]] = r_r.sh;
                r_nxt.pmask[r_r.cnt[PB-1:0]] = 1'b1;
                r_nxt.cnt[PB-1:0] = r_r.cnt[PB-1:0] + PB'(1);
              end
            endcase
            r_nxt.st = ack ? SS_ACK : SS_IDLE;
            r_nxt.sda_oe = ack;
          end
        end
        SS_ACK:
        begin
          if (fall)
          begin
            r_nxt.bits = 4'd0;
            r_nxt.sda_oe = 1'b0;
            r_nxt.st = SS_RX;
            if (r_r.rw)
              r_nxt = load_tx(r_nxt);
          end
        end
        SS_TX:
        begin
          if (fall)
          begin
            if (r_r.bits == `EE_TX_LAST)
            begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st = SS_MACK;
            end
            else
            begin
              r_nxt.bits = r_r.bits + 4'd1;
              r_nxt.sh = {r_r.sh[6:0], 1'b0};
              r_nxt.sda_oe = !r_r.sh[6];
            end
          end
        end
        SS_MACK:
        begin
          if (rise && sda_f)
            r_nxt.st = SS_IDLE;
          else if (fall)
            r_nxt = load_tx(r_nxt);
        end
        default:
        begin
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Array resets to the erased pattern; synchroniser and filter reset high, other control state to zero
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      r_r <= '0;
      r_r.filt <= 2'h3;
      r_r.prev <= 2'h3;
      r_r.s1 <= 2'h3;
      r_r.s2 <= 2'h3;
      r_r.mem <= '1;
    end
    else
      r_r <= r_nxt;
  end

  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = r_r.sda_oe;
  assign busy = r_r.busy;
endmodule // ee_slave
`default_nettype wire

// ==== i2c_serial_eeprom_slave_bench.sv ====
// Self-checking bench: master and memory slave joined over the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2c_serial_eeprom_slave_bench;
  localparam int TWR = 2000;
  logic clock, resetn, wp, busy, cmd_valid, cmd_ready, cmd_read, cmd_seladdr;
  logic wd_valid, wd_ready, rd_valid, done, nack, took;
  logic [2:0] cmd_sel, straps;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_len, wd_data, rd_data;
  logic [7:0] mem [256];
  logic [7:0] rx [$];
  logic [7:0] wq [$];
  int failures, samples_checked, seed, ctr, cycles;
  ee_bus_if bus_if();
  ee_slave #(.ADDR_W(8), .TWR_CYC(TWR)) ee_slave_inst (.clock(clock), .resetn(resetn), .bus(bus_if.slave),
    .strap_sel_bit0(straps[0]), .strap_sel_bit1(straps[1]), .strap_sel_bit2(straps[2]), .wp(wp), .busy(busy));
  ee_master #(.QTR_CYC(8)) ee_master_inst (.clock(clock), .resetn(resetn), .bus(bus_if.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_seladdr(cmd_seladdr),
    .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wd_valid(wd_valid), .wd_ready(wd_ready),
    .wd_data(wd_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
  ee_link_monitor #(.TWR_CYC(TWR)) ee_link_monitor_inst (.clock(clock), .resetn(resetn),
    .m_scl_o(bus_if.m_scl_o), .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
    .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda), .busy(busy));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  always @(posedge clock) took <= wd_valid && wd_ready;
  always @(negedge clock)
  begin
    if (took)
      void'(wq.pop_front());
    wd_valid = wq.size() > 0;
    wd_data = wq.size() > 0 ? wq[0] : 8'h00;
    if (rd_valid === 1'b1)
      rx.push_back(rd_data);
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input logic rd, input logic sa, input logic [2:0] sel, input logic [15:0] a, input int n);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_seladdr = sa;
    cmd_sel = sel;
    cmd_addr = a;
    cmd_len = 8'(n);
    while (!(cmd_ready === 1'b1 && bus_if.scl === 1'b1 && bus_if.sda === 1'b1))
      @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    while (done !== 1'b1)
      @(negedge clock);
  endtask
  // Model: top address bits ignored, 256-byte array with ADDR_W of 8
  task automatic rd_check(input logic [2:0] sel, input logic sa, input logic [15:0] a, input int n);
    rx.delete();
    run(1'b1, sa, sel, a, n);
    chk_flag(nack, sel != straps);
    if (sa)
      ctr = a & 255;
    if (sel == straps)
    begin
      for (int i = 0; i < n; i++)
        chk_byte(rx[i], mem[(ctr + i) & 255]);
      ctr = (ctr + n) & 255;
    end
  endtask
  task automatic poll(input logic [15:0] a, input logic exp_busy);
    int k;
    k = 0;
    // Write cycle starts on STOP, so busy already stands when the write command ends
    chk_flag(busy, exp_busy);
    do
    begin
      rx.delete();
      run(1'b1, 1'b1, straps, a, 1);
      if (k == 0)
        chk_flag(nack, exp_busy);
      k++;
    end
    while (nack === 1'b1);
    chk_byte(rx[0], mem[a & 255]);
    ctr = (a + 1) & 255;
  endtask
  task automatic wr(input logic [15:0] a, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      wq.push_back(d);
      if (!wp)
        mem[(a & 8'hc0) | ((a + i) & 63)] = d;
    end
    repeat (12) @(negedge clock);
    if (n > 8)
      chk_flag(wd_ready, 1'b0);
    run(1'b0, 1'b0, straps, a, n);
    chk_flag(nack, 1'b0);
    chk_byte(8'(wq.size()), 8'h00);
  endtask
  initial
  begin
    seed = 82602;
    {cmd_valid, cmd_read, cmd_seladdr, cmd_sel, cmd_addr, cmd_len, wd_valid, wd_data, wp} = '0;
    straps = 3'($random(seed));
    foreach (mem[i])
      mem[i] = 8'hff;
    resetn = 1'b0;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    wr(16'h8123, 1);
    poll(16'h8123, 1'b1);
    $display("test byte write done");
    wr(16'h7f45, 66);
    poll(16'h7f45, 1'b1);
    rd_check(straps, 1'b1, 16'h0040, 64);
    $display("test page wrap done");
    wp = 1'b1;
    wr(16'h0080, 3);
    poll(16'h0080, 1'b0);
    rd_check(straps, 1'b1, 16'h0080, 3);
    wp = 1'b0;
    $display("test write protect done");
    rd_check(straps, 1'b1, 16'h00fe, 4);
    rd_check(straps, 1'b0, 16'h0000, 2);
    $display("test counter wrap done");
    for (int s = 0; s < 8; s++)
      rd_check(3'(s), 1'b0, 16'h0000, 1);
    $display("test strap match done");
    tally_and_finish();
  end
endmodule // i2c_serial_eeprom_slave_bench
`default_nettype wire
